// file: inc/sfpf_params.svh
/*
  constants of the serial flash pin front end: status field positions,
  data widths, buffer depth and lane counts.
  assumes it is included by bare name, once per compile unit or more.
*/
`ifndef SFPF_PARAMS_SVH
`define SFPF_PARAMS_SVH

// status byte layout
`define SFPF_SR_W 8
`define SFPF_QE_BIT 6
`define SFPF_SR_RESET 8'h00

// data path
`define SFPF_BYTE_W 8
`define SFPF_LANES 4
`define SFPF_BITCNT_W 4
`define SFPF_FIFO_DEPTH 32
`define SFPF_FIFO_PTR_W 5

// synchroniser length for pin inputs
`define SFPF_SYNC_STAGES 2

// lane mode codes on the lane_mode port
`define SFPF_LM_CODE_SINGLE 2'h0
`define SFPF_LM_CODE_DUAL 2'h1
`define SFPF_LM_CODE_QUAD 2'h2

`endif

// file: inc/sfpf_pkg.sv
/*
  types of the serial flash pin front end: lane width and serial state.
  assumes nothing beyond a systemverilog compiler.
*/
package sfpf_pkg;

  // lanes in use for one clock of transfer, one-hot
  typedef enum logic [2:0] {
    SFPF_W_SINGLE = 3'b001,
    SFPF_W_DUAL = 3'b010,
    SFPF_W_QUAD = 3'b100
  } sfpf_width_t;

  // serial state, one-hot
  typedef enum logic [3:0] {
    SFPF_ST_IDLE = 4'b0001,
    SFPF_ST_SHIFT = 4'b0010,
    SFPF_ST_PAUSE = 4'b0100,
    SFPF_ST_RESET = 4'b1000
  } sfpf_state_t;

endpackage

// file: testbench/sfpf_frontend_asserts.sv
/*
  checker for the pin front end, bound to it.
  assumes it sees only the front end's ports, one clock domain.
*/
`timescale 1ns/1ps
`include "sfpf_params.svh"
module sfpf_frontend_asserts (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic [`SFPF_LANES-1:0] data_lane_in,
  input wire logic [`SFPF_LANES-1:0] data_lane_oe_n,
  input wire logic hw_reset_n,
  input wire logic dedicated_reset_part,
  input wire logic [`SFPF_SR_W-1:0] status_byte,
  input wire logic pin_function_select,
  input wire logic quad_command_mode,
  input wire logic tx_take,
  input wire logic selected,
  input wire logic paused,
  input wire logic in_hw_reset,
  input wire logic frame_end
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  // shared pin low, set up as reset input
  sequence s_shared_rst;
    (!dedicated_reset_part && pin_function_select && !status_byte[`SFPF_QE_BIT]
      && !quad_command_mode && !data_lane_in[3])[*6];
  endsequence
  // dedicated reset pin held low
  sequence s_ded_rst;
    (dedicated_reset_part && !hw_reset_n)[*6];
  endsequence
  // select released during a frame
  sequence s_sel_end;
    selected ##0 $rose(cs_n);
  endsequence
  property p_desel_float;
    cs_n[*6] |-> &data_lane_oe_n;
  endproperty
  a_desel_float: assert property (p_desel_float) else $error("lane driven, deselected");
  property p_pause_float;
    paused[*2] |-> data_lane_oe_n[1];
  endproperty
  a_pause_float: assert property (p_pause_float) else $error("lane1 driven in pause");
  property p_reset_float;
    in_hw_reset[*2] |-> &data_lane_oe_n;
  endproperty
  a_reset_float: assert property (p_reset_float) else $error("lane driven in reset");
  property p_shared_rst;
    s_shared_rst |-> in_hw_reset;
  endproperty
  a_shared_rst: assert property (p_shared_rst) else $error("shared reset missed");
  property p_ded_rst;
    s_ded_rst |-> in_hw_reset;
  endproperty
  a_ded_rst: assert property (p_ded_rst) else $error("dedicated reset missed");
  property p_frame_end;
    s_sel_end |-> ##[1:6] frame_end;
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("no frame end");
  property p_end_pulse;
    frame_end |=> !frame_end;
  endproperty
  a_end_pulse: assert property (p_end_pulse) else $error("frame end too long");
  property p_take_drive;
    tx_take |-> ##[0:1] !data_lane_oe_n[1];
  endproperty
  a_take_drive: assert property (p_take_drive) else $error("send lane not driven");
endmodule

bind sfpf_frontend sfpf_frontend_asserts sfpf_frontend_asserts_i (
  .mclk(mclk), .arst_n(arst_n), .cs_n(cs_n), .data_lane_in(data_lane_in),
  .data_lane_oe_n(data_lane_oe_n), .hw_reset_n(hw_reset_n),
  .dedicated_reset_part(dedicated_reset_part), .status_byte(status_byte),
  .pin_function_select(pin_function_select), .quad_command_mode(quad_command_mode),
  .tx_take(tx_take), .selected(selected), .paused(paused), .in_hw_reset(in_hw_reset),
  .frame_end(frame_end)
);

// file: testbench/sfpf_frontend_bench.sv
/*
  testbench of the pin front end: host model on the pins, core side here.
  assumes the checker is bound by its own file.
*/
`timescale 1ns/1ps
module sfpf_frontend_bench;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1; // always enabled
  logic hw_reset_n = 1'b1;
  logic dedicated_reset_part = 1'b0;
  logic [7:0] status_byte = 8'h00;
  logic pin_function_select = 1'b0;
  logic quad_command_mode = 1'b0;
  logic [1:0] lane_mode = 2'h0;
  logic drive_phase = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic rx_ready = 1'b0;
  logic sck, cs_n, tx_take, rx_valid, rx_space, rx_overflow;
  logic selected, paused, in_hw_reset, frame_end;
  logic [3:0] data_lane_in, data_lane_out, data_lane_oe_n;
  logic [7:0] rx_data, got;
  logic [3:0] rst_tbl [4] = '{4'b0111, 4'b0010, 4'b1110, 4'b1001}; // ded, sel, pin, expect
  int error_cnt = 0;
  int check_count = 0;
  always #2.5 mclk = ~mclk;
  sfpf_frontend sfpf_frontend_i (.mclk, .arst_n, .ce, .sck, .cs_n, .data_lane_in,
    .data_lane_out, .data_lane_oe_n, .hw_reset_n, .dedicated_reset_part, .status_byte,
    .pin_function_select, .quad_command_mode, .lane_mode, .drive_phase, .tx_data, .tx_take,
    .rx_data, .rx_valid, .rx_ready, .rx_space, .rx_overflow, .selected, .paused,
    .in_hw_reset, .frame_end);
  sfpf_host_model sfpf_host_model_i (.mclk, .dev_out(data_lane_out),
    .dev_oe_n(data_lane_oe_n), .sck, .cs_n, .lane(data_lane_in));
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk_flag(input string what, input logic exp, input logic seen);
    chk_byte(what, {7'h00, exp}, {7'h00, seen});
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // wait for a byte at the core side, check it, accept it
  task automatic take_rx(input logic [7:0] exp);
    int n;
    n = 0;
    @(negedge mclk);
    while (rx_valid !== 1'b1 && n < 80) begin
      @(negedge mclk);
      n++;
    end
    chk_flag("rx_valid", 1'b1, rx_valid);
    chk_byte("rx_data", exp, rx_data);
    rx_ready = 1'b1;
    @(negedge mclk);
    rx_ready = 1'b0;
    @(negedge mclk);
  endtask
  // pause mid-byte in a low clock phase, check pause flag and floating lane 1, resume
  task automatic hold_check;
    repeat (2) @(negedge sck);
    #12;
    sfpf_host_model_i.stall = 1'b1;
    sfpf_host_model_i.h_val[3] = 1'b0;
    #100;
    chk_flag("paused", 1'b1, paused);
    chk_flag("lane1_oe_n", 1'b1, data_lane_oe_n[1]);
    sfpf_host_model_i.h_val[3] = 1'b1;
    #40;
    sfpf_host_model_i.stall = 1'b0;
  endtask
  // one frame of one byte, optionally paused
  task automatic one_byte(input logic cpol, input int w, input logic [7:0] b, input bit hold);
    sfpf_host_model_i.start(cpol);
    fork
      sfpf_host_model_i.xfer(b, w, got);
      if (hold) hold_check();
    join
    sfpf_host_model_i.stop(cpol);
    if (!drive_phase) take_rx(b);
  endtask
  initial begin
    repeat (3) @(negedge mclk);
    arst_n = 1'b1;
    repeat (6) @(negedge mclk);
    chk_byte("idle_oe_n", 8'h0f, {4'h0, data_lane_oe_n});
    one_byte(1'b0, 1, 8'ha5, 1'b0);
    one_byte(1'b1, 1, 8'h5a, 1'b0);
    one_byte(1'b0, 1, 8'hb4, 1'b1);
    $display("test single done");
    sfpf_host_model_i.h_en = 4'hf;
    lane_mode = 2'h1;
    one_byte(1'b0, 2, 8'hc3, 1'b0);
    lane_mode = 2'h2;
    status_byte = 8'h40;
    one_byte(1'b1, 4, 8'h96, 1'b0);
    status_byte = 8'h00;
    quad_command_mode = 1'b1;
    one_byte(1'b0, 4, 8'h69, 1'b0);
    quad_command_mode = 1'b0;
    lane_mode = 2'h0;
    sfpf_host_model_i.h_en = 4'hd;
    drive_phase = 1'b1;
    tx_data = 8'h3c;
    $display("test lanes done");
    one_byte(1'b1, 1, 8'h00, 1'b1);
    chk_byte("tx_byte", 8'h3c, got);
    @(negedge mclk);
    drive_phase = 1'b0;
    $display("test send done");
    // hardware reset only between frames
    for (int k = 0; k < 4; k++) begin
      {dedicated_reset_part, pin_function_select, hw_reset_n} = rst_tbl[k][3:1];
      sfpf_host_model_i.h_val[3] = 1'b0;
      repeat (8) @(negedge mclk);
      chk_flag("in_hw_reset", rst_tbl[k][0], in_hw_reset);
      chk_byte("reset_oe_n", 8'h0f, {4'h0, data_lane_oe_n});
      {dedicated_reset_part, pin_function_select, hw_reset_n} = 3'b001;
      sfpf_host_model_i.h_val[3] = 1'b1;
      repeat (8) @(negedge mclk);
    end
    $display("test reset done");
    sfpf_host_model_i.start(1'b0);
    for (int k = 0; k < 34; k++) sfpf_host_model_i.xfer(k[7:0], 1, got);
    sfpf_host_model_i.stop(1'b0);
    @(negedge mclk);
    chk_flag("rx_space", 1'b0, rx_space);
    chk_flag("rx_overflow", 1'b1, rx_overflow);
    for (int k = 0; k < 32; k++) take_rx(k[7:0]);
    take_rx(8'h20);
    repeat (4) @(negedge mclk);
    chk_flag("rx_valid", 1'b0, rx_valid);
    chk_flag("rx_space", 1'b1, rx_space);
    $display("test buffer done");
    give_verdict();
  end
  // the run needs about 18 us; cut it off well beyond that
  initial begin
    #150000;
    error_cnt++;
    give_verdict();
  end
endmodule

// file: testbench/sfpf_host_model.sv
/*
  host model: makes serial clock and select, drives and samples lanes.
  assumes the device floats every lane it does not drive.
*/
`timescale 1ns/1ps
module sfpf_host_model (
  input wire logic mclk,
  input wire logic [3:0] dev_out,
  input wire logic [3:0] dev_oe_n,
  output logic sck,
  output logic cs_n,
  output logic [3:0] lane
);
  logic [3:0] h_val = 4'hf; // host drive values
  logic [3:0] h_en = 4'hd; // host drive enables
  logic stall = 1'b0; // hold the clock still
  logic tog = 1'b0; // filler for undriven lanes
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
  end
  // undriven lanes change every cycle
  always @(posedge mclk) tog <= ~tog;
  // wire level from both parties' enables
  assign lane = (~dev_oe_n & dev_out) | (dev_oe_n & h_en & h_val) | (dev_oe_n & ~h_en & {4{tog}});
  // park clock by polarity, then select
  task automatic start(input logic cpol);
    @(negedge mclk);
    sck = cpol;
    #24;
    cs_n = 1'b0;
    #24;
  endtask
  // park clock, deselect, set lane drive values high
  task automatic stop(input logic cpol);
    #24;
    sck = cpol;
    cs_n = 1'b1;
    h_val = 4'hf;
    #48;
  endtask
  // one byte on w lanes, msb first; drive in low phase, sample on rise
  task automatic xfer(input logic [7:0] tx, input int w, output logic [7:0] rx);
    logic [7:0] sh;
    sh = tx;
    rx = 8'h00;
    for (int i = 0; i < 8 / w; i++) begin
      sck = 1'b0;
      case (w)
        1: h_val[0] = sh[7];
        2: h_val[1:0] = sh[7:6];
        default: h_val = sh[7:4];
      endcase
      #24;
      while (stall) #8;
      sck = 1'b1;
      case (w)
        1: rx = {rx[6:0], lane[1]};
        2: rx = {rx[5:0], lane[1:0]};
        default: rx = {rx[3:0], lane};
      endcase
      sh = sh << w;
      #24;
    end
  endtask
endmodule

// file: verilog/sfpf_fifo.sv
/*
  flip-flop fifo with valid/ready on both sides.
  assumes one clock; depth is a power of two matching the pointer width.
*/
`timescale 1ns/1ps
module sfpf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int PW = 5
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_q [DEPTH]; // storage
  logic [PW:0] wr_q; // write pointer with wrap bit
  logic [PW:0] rd_q; // read pointer with wrap bit
  logic push; // accepted write
  logic pop; // accepted read

  // honest full and empty from the pointer pair
  assign in_ready = (wr_q[PW-1:0] != rd_q[PW-1:0]) || (wr_q[PW] == rd_q[PW]);
  assign out_valid = (wr_q != rd_q);
  assign out_data = mem_q[rd_q[PW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage write, no reset needed for data
  always_ff @(posedge mclk) begin
    if (ce && push) begin
      mem_q[wr_q[PW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (ce) begin
      if (flush) begin
        wr_q <= '0;
        rd_q <= '0;
      end else begin
        if (push) begin
          wr_q <= wr_q + 1'b1;
        end
        if (pop) begin
          rd_q <= rd_q + 1'b1;
        end
      end
    end
  end
endmodule

// file: verilog/sfpf_frontend.sv
/*
  pin front end of a serial nor flash: samples the host's clock and
  select, remaps the shared pins into data lanes, handles pause and the
  hardware reset input, and moves bytes between the pins and the core.
  assumes mclk is far faster than the serial clock (at least 4x) and that
  the core supplies the status byte, lane mode and turn-around point.
*/
`timescale 1ns/1ps
`include "sfpf_params.svh"
module sfpf_frontend
  import sfpf_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [`SFPF_LANES-1:0] data_lane_in,
  output logic [`SFPF_LANES-1:0] data_lane_out,
  output logic [`SFPF_LANES-1:0] data_lane_oe_n,
  input wire logic hw_reset_n,
  input wire logic dedicated_reset_part,
  input wire logic [`SFPF_SR_W-1:0] status_byte,
  input wire logic pin_function_select,
  input wire logic quad_command_mode,
  input wire logic [1:0] lane_mode,
  input wire logic drive_phase,
  input wire logic [`SFPF_BYTE_W-1:0] tx_data,
  output logic tx_take,
  output logic [`SFPF_BYTE_W-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_space,
  output logic rx_overflow,
  output logic selected,
  output logic paused,
  output logic in_hw_reset,
  output logic frame_end
);
  logic rst_q1; // reset release, first stage
  logic rst_n; // reset release, second stage
  logic sck_s; // synchronised serial clock
  logic cs_n_s; // synchronised select
  logic rstp_n_s; // synchronised dedicated reset pin
  logic [`SFPF_LANES-1:0] lane_s; // synchronised lane inputs
  logic sck_d_q; // previous serial clock level
  logic cs_n_d_q; // previous select level
  logic armed_q; // a select falling edge has been seen since reset
  logic sck_rise; // rising serial clock edge
  logic sck_fall; // falling serial clock edge
  logic cs_rise; // end of frame
  logic cs_fall; // start of frame
  logic qe; // quad enable from status
  logic lanes23; // lanes 2 and 3 carry data
  logic hold_pin; // fourth pin acts as pause
  logic hold_act; // pause in effect
  logic hwrst_act; // hardware reset in effect
  sfpf_width_t width; // lanes used per clock
  sfpf_state_t state_q; // serial state
  logic [`SFPF_BYTE_W-1:0] rx_sh_q; // incoming shift register
  logic [`SFPF_BITCNT_W-1:0] rx_cnt_q; // bits gathered in rx_sh_q
  logic [`SFPF_BYTE_W-1:0] tx_sh_q; // outgoing shift register
  logic [`SFPF_BITCNT_W-1:0] tx_cnt_q; // bits left in tx_sh_q
  logic tx_live_q; // this frame has driven a bit, lanes come back after pause
  logic [`SFPF_BYTE_W-1:0] rx_next; // shift register after this edge
  logic [`SFPF_BITCNT_W-1:0] step; // bits per clock
  logic push_q; // byte ready for the fifo
  logic [`SFPF_BYTE_W-1:0] push_data_q; // that byte
  logic f_in_ready; // fifo has room
  logic f_out_valid; // fifo has a byte
  logic [`SFPF_BYTE_W-1:0] f_out_data; // fifo head
  logic f_pop; // move head into the output stage
  // bits per serial clock for a lane width
  function automatic logic [`SFPF_BITCNT_W-1:0] bits_of(input sfpf_width_t w);
    case (w)
      SFPF_W_DUAL: bits_of = 4'h2;
      SFPF_W_QUAD: bits_of = 4'h4;
      default: bits_of = 4'h1;
    endcase
  endfunction
  // shift new lane bits into the low end, msb arrives first
  function automatic logic [`SFPF_BYTE_W-1:0] shift_in(input logic [`SFPF_BYTE_W-1:0] sh,
                                                     input sfpf_width_t w,
                                                     input logic [`SFPF_LANES-1:0] ln);
    case (w)
      SFPF_W_DUAL: shift_in = {sh[5:0], ln[1:0]};
      SFPF_W_QUAD: shift_in = {sh[3:0], ln};
      default: shift_in = {sh[6:0], ln[0]};
    endcase
  endfunction
  // reset release through two flip-flops
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end
  // pin synchroniser; idle-high pins are inverted in and out so reset reads idle
  logic [7:0] sync_q;
  sfpf_sync #(.W(8)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .init_val(8'h7e),
    .d({sck, cs_n, hw_reset_n, data_lane_in, 1'b0}),
    .q(sync_q)
  );
  assign sck_s = sync_q[7];
  assign cs_n_s = ~sync_q[6];
  assign rstp_n_s = ~sync_q[5];
  assign lane_s = ~sync_q[4:1];
  // edge detection on the synchronised copies
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sck_d_q <= 1'b0;
      cs_n_d_q <= 1'b1;
    end else if (ce) begin
      sck_d_q <= sck_s;
      cs_n_d_q <= cs_n_s;
    end
  end
  // both idle levels are legal, only edges matter
  assign sck_rise = sck_s && !sck_d_q;
  assign sck_fall = !sck_s && sck_d_q;
  assign cs_rise = cs_n_s && !cs_n_d_q;
  assign cs_fall = !cs_n_s && cs_n_d_q;
  // pin function decode
  assign qe = status_byte[`SFPF_QE_BIT];
  assign lanes23 = qe || quad_command_mode;
  // shared variant uses the select bit, dedicated variant ignores it
  assign hold_pin = !lanes23 && (dedicated_reset_part || !pin_function_select);
  assign hold_act = hold_pin && !cs_n_s && !lane_s[3];
  assign hwrst_act = dedicated_reset_part ? !rstp_n_s
                   : (!lanes23 && pin_function_select && !lane_s[3]);
  // lane width from core mode; quad needs lanes 2 and 3 free
  always_comb begin
    if (quad_command_mode || (lane_mode == `SFPF_LM_CODE_QUAD && lanes23)) begin
      width = SFPF_W_QUAD;
    end else if (lane_mode == `SFPF_LM_CODE_DUAL) begin
      width = SFPF_W_DUAL;
    end else begin
      width = SFPF_W_SINGLE;
    end
  end
  assign step = bits_of(width);
  assign rx_next = shift_in(rx_sh_q, width, lane_s);
  // select arming: nothing is taken before the first select falling edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
    end else if (ce) begin
      if (hwrst_act) begin
        armed_q <= 1'b0;
      end else if (cs_fall) begin
        armed_q <= 1'b1;
      end
    end
  end
  // serial state machine
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SFPF_ST_RESET;
    end else if (ce) begin
      if (hwrst_act) begin
        state_q <= SFPF_ST_RESET;
      end else begin
        case (state_q)
          SFPF_ST_RESET: state_q <= SFPF_ST_IDLE;
          SFPF_ST_IDLE: begin
            if (cs_fall) begin
              state_q <= SFPF_ST_SHIFT;
            end
          end
          SFPF_ST_SHIFT: begin
            if (cs_n_s) begin
              state_q <= SFPF_ST_IDLE;
            end else if (hold_act) begin
              state_q <= SFPF_ST_PAUSE;
            end
          end
          SFPF_ST_PAUSE: begin
            if (cs_n_s) begin
              state_q <= SFPF_ST_IDLE;
            end else if (!hold_act) begin
              state_q <= SFPF_ST_SHIFT;
            end
          end
          default: state_q <= SFPF_ST_RESET;
        endcase
      end
    end
  end
  // receive shifter: rising edges while shifting and not turned around
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh_q <= '0;
      rx_cnt_q <= '0;
      push_q <= 1'b0;
      push_data_q <= '0;
    end else if (ce) begin
      push_q <= 1'b0;
      if (hwrst_act || cs_n_s || state_q != SFPF_ST_SHIFT || !armed_q) begin
        if (state_q != SFPF_ST_PAUSE || cs_n_s || hwrst_act) begin
          rx_cnt_q <= '0; // pause keeps partial bits
        end
      end else if (sck_rise && !drive_phase && !hold_act) begin
        rx_sh_q <= rx_next;
        if (rx_cnt_q + step >= 4'h8) begin
          rx_cnt_q <= '0;
          push_q <= 1'b1;
          push_data_q <= rx_next;
        end else begin
          rx_cnt_q <= rx_cnt_q + step;
        end
      end
    end
  end
  // transmit shifter and lane drivers: data changes only on falling edges; enables also switch on pause, its end, deselect and reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh_q <= '0;
      tx_cnt_q <= '0;
      tx_take <= 1'b0;
      data_lane_out <= '0;
      data_lane_oe_n <= '1;
      tx_live_q <= 1'b0;
    end else if (ce) begin
      tx_take <= 1'b0;
      if (hwrst_act || cs_n_s || !drive_phase || !armed_q) begin
        tx_cnt_q <= '0;
        tx_live_q <= 1'b0;
        data_lane_oe_n <= '1;
      end else if (hold_act || state_q == SFPF_ST_PAUSE) begin
        data_lane_oe_n <= '1; // shifter untouched
      end else if (sck_fall && state_q == SFPF_ST_SHIFT) begin
        logic [`SFPF_BYTE_W-1:0] src;
        src = (tx_cnt_q == '0) ? tx_data : tx_sh_q;
        tx_take <= (tx_cnt_q == '0);
        tx_live_q <= 1'b1;
        case (width)
          SFPF_W_QUAD: begin
            data_lane_out <= src[7:4];
            data_lane_oe_n <= 4'h0;
            tx_sh_q <= {src[3:0], 4'h0};
          end
          SFPF_W_DUAL: begin
            data_lane_out <= {2'h0, src[7:6]};
            data_lane_oe_n <= 4'hc;
            tx_sh_q <= {src[5:0], 2'h0};
          end
          default: begin
            data_lane_out <= {2'h0, src[7], 1'b0}; // serial output pin
            data_lane_oe_n <= 4'hd;
            tx_sh_q <= {src[6:0], 1'b0};
          end
        endcase
        tx_cnt_q <= ((tx_cnt_q == '0) ? 4'h8 : tx_cnt_q) - step;
      end else if (tx_live_q && state_q == SFPF_ST_SHIFT) begin // pause over, drive again
        data_lane_oe_n <= {{2{width != SFPF_W_QUAD}}, 1'b0, width == SFPF_W_SINGLE};
      end
    end
  end
  // receive buffer toward the core
  sfpf_fifo #(
    .WIDTH(`SFPF_BYTE_W),
    .DEPTH(`SFPF_FIFO_DEPTH),
    .PW(`SFPF_FIFO_PTR_W)
  ) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .flush(hwrst_act),
    .in_valid(push_q),
    .in_ready(f_in_ready),
    .in_data(push_data_q),
    .out_valid(f_out_valid),
    .out_ready(f_pop),
    .out_data(f_out_data)
  );
  assign f_pop = f_out_valid && (!rx_valid || rx_ready);
  // registered output stage of the buffer, plus overflow and room flags
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_valid <= 1'b0;
      rx_data <= '0;
      rx_space <= 1'b1;
      rx_overflow <= 1'b0;
    end else if (ce) begin
      rx_space <= f_in_ready;
      if (f_pop) begin
        rx_valid <= 1'b1;
        rx_data <= f_out_data;
      end else if (rx_ready) begin
        rx_valid <= 1'b0;
      end
      // the host cannot be stalled, so a byte into a full buffer is lost
      if (push_q && !f_in_ready) begin
        rx_overflow <= 1'b1;
      end else if (cs_fall) begin
        rx_overflow <= 1'b0;
      end
    end
  end
  // status outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      selected <= 1'b0;
      paused <= 1'b0;
      in_hw_reset <= 1'b0;
      frame_end <= 1'b0;
    end else if (ce) begin
      selected <= !cs_n_s && !hwrst_act && armed_q;
      paused <= hold_act && !hwrst_act;
      in_hw_reset <= hwrst_act;
      frame_end <= cs_rise && !hwrst_act;
    end
  end
endmodule

// file: verilog/sfpf_sync.sv
/*
  two flip-flop synchroniser for a bundle of independent levels.
  assumes each bit is a slow level or is only sampled for its edges later.
*/
`timescale 1ns/1ps
module sfpf_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] init_val,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q; // first stage, read only by the second

  // two stages, frozen with the clock enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else if (ce) begin
      meta_q <= d ^ init_val;
      q <= meta_q;
    end
  end
endmodule
